// ===== logic/alpha_pkg.sv
// Constants and carrier types for the alpha field decoder
package alpha_pkg;
    localparam logic [7:0] SCHEME_DIRECT = 8'h80;
    localparam logic [7:0] SCHEME_BASE8  = 8'h81;
    localparam logic [7:0] SCHEME_BASE16 = 8'h82;
    localparam logic [7:0] PAD_BYTE      = 8'hff;
    localparam int         OFFSET_BIT    = 7;
    localparam int         CHARSET_SMALL = 128;

    typedef enum logic [1:0] {
        CODE_PLAIN  = 2'b00,
        CODE_DIRECT = 2'b01,
        CODE_BASE8  = 2'b10,
        CODE_BASE16 = 2'b11
    } coding_e;

    typedef enum logic [2:0] {
        ST_LEAD  = 3'b000,
        ST_COUNT = 3'b001,
        ST_BASEH = 3'b010,
        ST_BASEL = 3'b011,
        ST_BODY  = 3'b100,
        ST_HIGH  = 3'b101,
        ST_LOW   = 3'b110,
        ST_SKIP  = 3'b111
    } dec_state_e;

    // One field byte; last marks the final byte of the field
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } field_byte_s;

    // One decoded character; wide marks a 16-bit code point
    typedef struct packed {
        logic [15:0] code;
        logic        wide;
        logic [1:0]  coding;
    } char_out_s;
endpackage : alpha_pkg

// ===== logic/alpha_field_decoder.sv
// Alpha field decoder: field bytes in, character code points out
// What this block does
// - Leading byte 80 means each following byte pair is one 16-bit char.
// - Direct scheme: earlier byte is high half, later byte low half.
// - Direct scheme: FF pad pairs and odd trailing byte emit nothing.
// - Leading 81: byte two is count, byte three is base bits 14..7.
// - Scheme 81 bytes: top bit clear plain char, set adds offset.
// - Leading 82: byte two count, bytes three and four full base.
// - Scheme 82 bytes from fifth: top bit selects plain or offset.
// - One coding per field; the lead byte fixes it for the field.
// - All three schemes are always accepted, whatever the set size.
`timescale 1ns/1ns
module alpha_field_decoder
    import alpha_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        NRST,
    input  wire field_byte_s IN_BYTE,
    input  wire logic        IN_VALID,
    output logic             IN_READY,
    output char_out_s        OUT_CHAR,
    output logic             OUT_VALID,
    input  wire logic        OUT_READY,
    output logic             FIELD_DONE
);
    dec_state_e  state,      next_state;
    coding_e     coding,     next_coding;
    logic [7:0]  count,      next_count;
    logic [15:0] base,       next_base;
    logic [7:0]  high,       next_high;
    char_out_s   out_char,   next_out_char;
    logic        out_valid,  next_out_valid;
    logic        done,       next_done;

    logic take;
    logic [7:0] b;
    logic       is_last;

    // Stall input while a character waits; keeps output ordering simple
    assign IN_READY   = ~out_valid | OUT_READY;
    assign take       = IN_VALID & IN_READY;
    assign b          = IN_BYTE.data;
    assign is_last    = IN_BYTE.last;
    assign OUT_CHAR   = out_char;
    assign OUT_VALID  = out_valid;
    assign FIELD_DONE = done;

    // Offset or plain decode of one byte in a base-pointer scheme
    function automatic char_out_s base_char(input logic [7:0] v,
                                            input logic [15:0] bp,
                                            input coding_e c);
        char_out_s r;
        r.coding = c;
        if (v[OFFSET_BIT]) begin
            r.code = bp + {9'h000, v[6:0]};
            r.wide = 1'b1;
        end else begin
            r.code = {9'h000, v[6:0]};
            r.wide = 1'b0;
        end
        return r;
    endfunction : base_char

    // Next-state and output computation
    always_comb begin
        next_state     = state;
        next_coding    = coding;
        next_count     = count;
        next_base      = base;
        next_high      = high;
        next_out_char  = out_char;
        next_out_valid = out_valid & ~OUT_READY;
        next_done      = 1'b0;
        if (take) begin
            case (state)
                ST_LEAD: begin
                    // Lead byte fixes the coding for the whole field
                    if (b == SCHEME_DIRECT) begin
                        next_coding = CODE_DIRECT;
                        next_state  = ST_HIGH;
                    end else if (b == SCHEME_BASE8 ||
                                 b == SCHEME_BASE16) begin
                        next_coding = (b == SCHEME_BASE8) ? CODE_BASE8
                                                          : CODE_BASE16;
                        next_state  = ST_COUNT;
                    end else begin
                        next_coding = CODE_PLAIN;
                        if (b == PAD_BYTE) begin
                            next_state = ST_SKIP;
                        end else begin
                            next_out_char.code   = {9'h000, b[6:0]};
                            next_out_char.wide   = 1'b0;
                            next_out_char.coding = CODE_PLAIN;
                            next_out_valid       = 1'b1;
                            next_state           = ST_BODY;
                        end
                    end
                end
                ST_COUNT: begin
                    next_count = b;
                    next_state = ST_BASEH;
                end
                ST_BASEH: begin
                    if (coding == CODE_BASE8) begin
                        next_base  = {1'b0, b, 7'h00};
                        next_state = ST_BODY;
                    end else begin
                        next_base  = {b, 8'h00};
                        next_state = ST_BASEL;
                    end
                end
                ST_BASEL: begin
                    next_base  = {base[15:8], b};
                    next_state = ST_BODY;
                end
                ST_BODY: begin
                    if (coding == CODE_PLAIN) begin
                        if (b == PAD_BYTE) begin
                            next_state = ST_SKIP;
                        end else begin
                            next_out_char.code   = {9'h000, b[6:0]};
                            next_out_char.wide   = 1'b0;
                            next_out_char.coding = CODE_PLAIN;
                            next_out_valid       = 1'b1;
                        end
                    end else if (count != 8'h00) begin
                        // Count limits output, so FF may be a real char
                        next_out_char  = base_char(b, base, coding);
                        next_out_valid = 1'b1;
                        next_count     = count - 8'h01;
                    end
                end
                ST_HIGH: begin
                    next_high  = b;
                    next_state = ST_LOW;
                end
                ST_LOW: begin
                    if ({high, b} == {PAD_BYTE, PAD_BYTE}) begin
                        next_state = ST_SKIP;
                    end else begin
                        next_out_char.code   = {high, b};
                        next_out_char.wide   = 1'b1;
                        next_out_char.coding = CODE_DIRECT;
                        next_out_valid       = 1'b1;
                        next_state           = ST_HIGH;
                    end
                end
                default: begin
                    next_state = ST_SKIP;
                end
            endcase
            // Field end returns to lead; a lone high byte is dropped
            if (is_last) begin
                next_state = ST_LEAD;
                next_done  = 1'b1;
            end
        end
    end

    // Registers
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            state     <= ST_LEAD;
            coding    <= CODE_PLAIN;
            count     <= 8'h00;
            base      <= 16'h0000;
            high      <= 8'h00;
            out_char  <= '0;
            out_valid <= 1'b0;
            done      <= 1'b0;
        end else begin
            state     <= next_state;
            coding    <= next_coding;
            count     <= next_count;
            base      <= next_base;
            high      <= next_high;
            out_char  <= next_out_char;
            out_valid <= next_out_valid;
            done      <= next_done;
        end
    end

    // Direct pair: output is exactly the two captured bytes
    a_direct_pair: assert property (@(posedge REF_CLK) disable iff (!NRST)
        take && state == ST_LOW && !({high, b} == 16'hffff)
        |=> out_valid && out_char.code[15:8] == $past(high)
            && out_char.code[7:0] == $past(b))
        else $error("direct pair mis-decoded");

    a_direct_pad: assert property (@(posedge REF_CLK) disable iff (!NRST)
        take && state == ST_LOW && {high, b} == 16'hffff && OUT_READY
        |=> !out_valid)
        else $error("pad pair emitted a char");

    a_base8_ptr: assert property (@(posedge REF_CLK) disable iff (!NRST)
        take && state == ST_BASEH && coding == CODE_BASE8
        |=> base[15] == 1'b0 && base[6:0] == 7'h00 && base[14:7] == $past(b))
        else $error("base pointer wrong");

    a_offset_add: assert property (@(posedge REF_CLK) disable iff (!NRST)
        take && state == ST_BODY && coding != CODE_PLAIN
        && count != 8'h00 && b[7]
        |=> out_valid && out_char.wide
            && out_char.code == $past(base) + {9'h000, $past(b[6:0])})
        else $error("offset char wrong");

    a_count_stop: assert property (@(posedge REF_CLK) disable iff (!NRST)
        take && state == ST_BODY && coding != CODE_PLAIN
        && count == 8'h00 && OUT_READY
        |=> !out_valid)
        else $error("char beyond count");

    a_plain_stop: assert property (@(posedge REF_CLK) disable iff (!NRST)
        take && coding == CODE_PLAIN && state == ST_BODY && b == 8'hff
        && OUT_READY |=> !out_valid)
        else $error("plain pad emitted");

    a_lead_direct: assert property (@(posedge REF_CLK) disable iff (!NRST)
        take && state == ST_LEAD && b == 8'h80 && !is_last
        |=> state == ST_HIGH && coding == CODE_DIRECT)
        else $error("lead 80 not direct");

    a_lead_base16: assert property (@(posedge REF_CLK) disable iff (!NRST)
        take && state == ST_LEAD && b == SCHEME_BASE16 && !is_last
        |=> state == ST_COUNT && coding == CODE_BASE16)
        else $error("lead 82 not base16");

    a_coding_fixed: assert property (@(posedge REF_CLK) disable iff (!NRST)
        state != ST_LEAD && $past(state) != ST_LEAD |-> $stable(coding))
        else $error("coding changed mid field");

    a_stall_hold: assert property (@(posedge REF_CLK) disable iff (!NRST)
        out_valid && !OUT_READY |=> out_valid && $stable(out_char))
        else $error("output dropped under stall");

    a_base16_low: assert property (@(posedge REF_CLK) disable iff (!NRST)
        take && state == ST_BASEL |=> base[7:0] == $past(b))
        else $error("base low byte wrong");
endmodule : alpha_field_decoder

// ===== tb/card_stream_model.sv
// Card-side byte source and display-side character sink for the decoder
`timescale 1ns/1ns
module card_stream_model
    import alpha_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  in_ready,
    output field_byte_s in_byte,
    output logic        in_valid,
    output logic        out_ready
);
    bit stall_on = 1'h0;

    initial begin
        in_byte   = '0;
        in_valid  = 1'h0;
        out_ready = 1'h1;
    end

    // Sink stalls at random once enabled, so held output gets exercised
    always @(posedge clk) begin
        #1;
        out_ready = stall_on ? ($urandom_range(3) != 0) : 1'h1;
    end

    // Bytes held until taken; ready is read where it is settled
    task automatic send_field(input logic [7:0] b[$]);
        logic ok;
        for (int i = 0; i < b.size(); i++) begin
            in_byte  = '{data: b[i], last: (i == b.size() - 1)};
            in_valid = 1'h1;
            do begin
                @(negedge clk);
                ok = in_ready;
                @(posedge clk);
            end while (ok !== 1'h1);
            #1;
        end
        // Released data is inverted so a stale byte cannot pass for valid
        in_valid     = 1'h0;
        in_byte.data = ~in_byte.data;
        // One idle edge so the next field never re-drives in this step
        @(posedge clk);
        #1;
    endtask : send_field
endmodule : card_stream_model

// ===== tb/testbench.sv
// Self-checking bench for the alpha field decoder
`timescale 1ns/1ns
module testbench;
    import alpha_pkg::*;
    logic        ref_clk;
    logic        nrst;
    field_byte_s in_byte;
    logic        in_valid;
    logic        in_ready;
    char_out_s   out_char;
    logic        out_valid;
    logic        out_ready;
    logic        field_done;
    char_out_s   exp_q[$];
    int          err_total;
    int          tests_run;
    int          done_seen;
    int          fields_sent;

    alpha_field_decoder i_dut (.REF_CLK(ref_clk), .NRST(nrst),
        .IN_BYTE(in_byte), .IN_VALID(in_valid), .IN_READY(in_ready),
        .OUT_CHAR(out_char), .OUT_VALID(out_valid),
        .OUT_READY(out_ready), .FIELD_DONE(field_done));
    card_stream_model i_src (.clk(ref_clk), .in_ready(in_ready),
        .in_byte(in_byte), .in_valid(in_valid), .out_ready(out_ready));

    initial begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end

    function automatic char_out_s mk(input logic [7:0] x,
                                     input logic [15:0] bp,
                                     input logic [1:0] c);
        return x[7] ? {bp + {9'h000, x[6:0]}, 1'h1, c}
                    : {9'h000, x[6:0], 1'h0, c};
    endfunction : mk

    // Expected characters of one field, worked out from the coding rules
    function automatic void note_field(input logic [7:0] b[$]);
        logic [15:0] base;
        int          start;
        fields_sent++;
        start = (b[0] == SCHEME_BASE16) ? 4 : 3;
        if (b[0] == SCHEME_DIRECT) begin
            for (int i = 1; i + 1 < b.size(); i += 2) begin
                if (b[i] == PAD_BYTE && b[i+1] == PAD_BYTE) break;
                exp_q.push_back({b[i], b[i+1], 1'h1, 2'h1});
            end
        end else if (b[0] == SCHEME_BASE8 || b[0] == SCHEME_BASE16) begin
            base = (b[0] == SCHEME_BASE8) ? {1'h0, b[2], 7'h00}
                                          : {b[2], b[3]};
            for (int k = 0; k < b[1] && start + k < b.size(); k++)
                exp_q.push_back(mk(b[start+k], base, b[0][1:0] + 2'h1));
        end else begin
            for (int i = 0; i < b.size() && b[i] != PAD_BYTE; i++)
                exp_q.push_back(mk(b[i], 16'h0000, 2'h0));
        end
    endfunction : note_field

    task automatic run(input logic [7:0] b[$]);
        note_field(b);
        i_src.send_field(b);
    endtask : run

    // Random field of one coding; bytes past count or pad are junk
    task automatic rand_field(input int kind);
        logic [7:0] b[$];
        int         n;
        n = $urandom_range(5);
        case (kind)
            0: b = '{SCHEME_DIRECT};
            1: b = '{SCHEME_BASE8, 8'(n), 8'($urandom)};
            2: b = '{SCHEME_BASE16, 8'(n), 8'($urandom), 8'($urandom)};
            default: b = '{};
        endcase
        repeat (2 * n + 1) b.push_back(8'($urandom_range(kind ? 255 : 254)));
        // Even-length direct field: writer pads the unusable last byte
        if (kind == 0) b[b.size() - 1] = PAD_BYTE;
        if (kind == 3) begin
            b = '{};
            repeat (n + 1) b.push_back(8'($urandom_range(126)));
            b.push_back(PAD_BYTE);
            b.push_back(8'($urandom));
        end
        run(b);
    endtask : rand_field

    task automatic chk_char(input char_out_s e, input char_out_s g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("Error %0t char exp %h got %h", $time, e, g);
        end
    endtask : chk_char

    task automatic chk_int(input int e, input int g);
        tests_run++;
        if (g != e) begin
            err_total++;
            $display("Error %0t count exp %0d got %0d", $time, e, g);
        end
    endtask : chk_int

    task automatic report_and_stop;
        $display("Compares %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // Oldest expected character is taken whenever the sink accepts one
    always @(negedge ref_clk) begin
        if (out_valid === 1'h1 && out_ready === 1'h1) begin
            if (exp_q.size() == 0) chk_int(0, 1);
            else chk_char(exp_q.pop_front(), out_char);
        end
        if (field_done === 1'h1) done_seen++;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        $display("Error %0t run did not finish", $time);
        report_and_stop();
    end

    initial begin
        void'($urandom(1));
        nrst = 1'h0;
        repeat (12) @(posedge ref_clk);
        #1;
        nrst = 1'h1;
        run('{8'h80, 8'h01, 8'h02});
        run('{8'h80, 8'h4e, 8'h2d, 8'h00, 8'h41, 8'hff, 8'hff, 8'h12});
        run('{8'h80, 8'h01, 8'h02, 8'h03, 8'hff, 8'hff});
        run('{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'ha6, 8'h21, 8'hff,
              8'hff});
        run('{8'h82, 8'h05, 8'h05, 8'h30, 8'h2d, 8'h82, 8'hd3, 8'h2d,
              8'h31});
        run('{8'h81, 8'h00, 8'h13, 8'h95});
        run('{8'h41, 8'h42, 8'hff, 8'h43});
        run('{8'hff, 8'h41});
        i_src.stall_on = 1'h1;
        for (int i = 0; i < 24; i++) rand_field(i % 4);
        for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
        chk_int(fields_sent, done_seen);
        chk_int(0, exp_q.size());
        report_and_stop();
    end
endmodule : testbench
